//--- rtl/seq_prog_erase_defs.vh
/*
  Constants for the sequential program / block erase sequencer.
  Assumes inclusion by bare name from rtl/.
*/
`ifndef SEQ_PROG_ERASE_DEFS_VH
`define SEQ_PROG_ERASE_DEFS_VH

// ==========================================
// Opcodes
`define OP_SEQ_PROG_A 8'had
`define OP_SEQ_PROG_B 8'haf
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hd8
`define OP_WRITE_DISABLE 8'h04
`define OP_WRITE_ENABLE 8'h06
`define OP_READ_STATUS 8'h05

// ==========================================
// Status byte fields
`define STAT_BUSY_BIT 0
`define STAT_WEL_BIT 1
`define STAT_EPE_BIT 5

// ==========================================
// Array geometry
`define ADDR_LAST 24'h0fffff
`define SECTOR_SHIFT 16
`define MASK_4K 24'hfff000
`define MASK_32K 24'hff8000
`define MASK_64K 24'hff0000

// ==========================================
// Timing, times in us at 250 MHz
`define CLK_MHZ 250
`define BYTE_PROGRAM_TIME_US 7
`define BLOCK_ERASE_TIME_US 50000

`endif

//--- rtl/spi_frame_rx.v
/*
  SPI mode 0/3 receiver: samples SCK, CS_n and SI on i_clk, delivers bytes.
  Assumes SCK well below i_clk/4 (32 ns in the bench).
*/
module spi_frame_rx (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Pins
  input wire i_sck,
  input wire i_cs_n,
  input wire i_si,
  input wire i_so_bit,
  // Frame events
  output reg o_frame_start,
  output reg o_frame_end,
  output reg o_byte_valid,
  output reg [7:0] o_byte,
  output reg o_aligned,
  output reg o_fall,
  output reg o_so
);
  // ==========================================
  // Two-stage synchronisers
  reg [1:0] sck_sync_reg, cs_sync_reg, si_sync_reg;
  reg sck_d_reg, cs_d_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  wire sck_s = sck_sync_reg[1];
  wire cs_s = cs_sync_reg[1];
  wire rise = sck_s & ~sck_d_reg;
  wire fall = ~sck_s & sck_d_reg;
  always @(posedge i_clk) begin
    if (i_reset) begin
      sck_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      si_sync_reg <= 2'h0;
      sck_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      o_frame_start <= 1'b0;
      o_frame_end <= 1'b0;
      o_byte_valid <= 1'b0;
      o_byte <= 8'h00;
      o_aligned <= 1'b1;
      o_fall <= 1'b0;
      o_so <= 1'b0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], i_sck};
      cs_sync_reg <= {cs_sync_reg[0], i_cs_n};
      si_sync_reg <= {si_sync_reg[0], i_si};
      sck_d_reg <= sck_s;
      cs_d_reg <= cs_s;
      o_frame_start <= cs_d_reg & ~cs_s;
      o_frame_end <= ~cs_d_reg & cs_s;
      o_byte_valid <= 1'b0;
      o_fall <= ~cs_s & fall;
      if (fall & ~cs_s) begin
        o_so <= i_so_bit;
      end
      if (cs_s) begin
        bit_cnt_reg <= 3'h0;
        if (cs_d_reg) begin
          o_aligned <= 1'b1;
        end
      end else if (rise) begin
        shift_reg <= {shift_reg[6:0], si_sync_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        o_aligned <= (bit_cnt_reg == 3'h7);
        if (bit_cnt_reg == 3'h7) begin
          o_byte_valid <= 1'b1;
          o_byte <= {shift_reg[6:0], si_sync_reg[1]};
        end
      end
    end
  end
endmodule // spi_frame_rx

//--- rtl/seq_prog_erase.v
/*
  Sequential byte program and block erase sequencer of a serial flash.
  Assumes the array and sector protection bits sit outside, reached by
  a one-cycle write/erase strobe and a protect lookup port.
*/
// Function
// RULE1: Sequential mode entry needs write enable latch already set by host.
// RULE2: Opcode ADh/AFh, first frame carries three address bytes then data byte.
// RULE3: Frame end starts self-timed byte program at held address.
// RULE4: Later frames carry opcode and data only; counter supplies next address.
// RULE5: Active sequential mode accepts cycles without fresh write enable.
// RULE6: Write disable frame clears latch and leaves sequential mode.
// RULE7: Only the last complete data byte of a frame is programmed.
// RULE8: Missing data or misaligned end aborts program and clears latch.
// RULE9: Protected start address aborts at frame end and clears latch.
// RULE10: Counter never wraps; after last byte mode ends, latch cleared.
// RULE11: Crossing into protected sector ends mode and clears latch.
// RULE12: Status reads allowed while busy and report busy.
// RULE13: Host polls status rather than waiting the full program time.
// RULE14: Failed program or erase sets the program/erase error flag.
// RULE15: Opcode picks erase size 4K, 32K or 64K; erased bits read one.
// RULE16: Block erase needs write enable latch set beforehand.
// RULE17: Erase takes opcode and three address bytes, extras ignored.
// RULE18: Low address bits inside the block are not decoded.
// RULE19: Short address or misaligned end aborts erase without erasing.
// RULE20: Any protected sector inside the block cancels the erase.
// RULE21: Erase aborts for short address or protection clear the latch.
// RULE22: Successful erase clears the latch before it completes.
// RULE23: Write disable is opcode 04h alone in its frame; code also accepts 04h followed by whole extra bytes.
// RULE24: Write enable is opcode 06h; latch set at frame end.
// RULE25: After reset sequential mode is off.
`include "seq_prog_erase_defs.vh"

module seq_prog_erase #(
  parameter BYTE_PROGRAM_CYCLES = `BYTE_PROGRAM_TIME_US * `CLK_MHZ,
  parameter BLOCK_ERASE_CYCLES = `BLOCK_ERASE_TIME_US * `CLK_MHZ
) (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // SPI pins
  input wire i_sck,
  input wire i_cs_n,
  input wire i_si,
  output wire o_so,
  output wire o_so_oe_n,
  // Sector protection lookup, one bit per 64K sector
  input wire [15:0] i_sector_protected,
  // Array operations
  output reg o_prog_strobe,
  output reg o_erase_strobe,
  output reg [23:0] o_array_byte_address,
  output reg [23:0] o_erase_mask,
  output reg [7:0] o_prog_data,
  input wire i_op_fail,
  // Status
  output wire o_busy,
  output wire o_write_enable_latch,
  output wire o_program_erase_error_flag,
  output wire o_seq_mode
);
  // ==========================================
  // Cycle counts derived from times
  localparam [31:0] PROG_CYC = BYTE_PROGRAM_CYCLES;
  localparam [31:0] ERASE_CYC = BLOCK_ERASE_CYCLES;

  // Command states
  localparam [2:0] S_OPCODE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_DATA = 3'd2;
  localparam [2:0] S_STATUS = 3'd3;
  localparam [2:0] S_IGNORE = 3'd4;

  wire frame_start;
  wire frame_end;
  wire byte_valid;
  wire aligned;
  wire sck_fall;
  wire [7:0] rx_byte;
  reg so_bit;

  spi_frame_rx u_rx (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_sck(i_sck),
    .i_cs_n(i_cs_n),
    .i_si(i_si),
    .i_so_bit(so_bit),
    .o_frame_start(frame_start),
    .o_frame_end(frame_end),
    .o_byte_valid(byte_valid),
    .o_byte(rx_byte),
    .o_aligned(aligned),
    .o_fall(sck_fall),
    .o_so(o_so)
  );

  // ==========================================
  // Registers
  reg [2:0] state_reg;
  reg [7:0] opcode_reg;
  reg [1:0] addr_cnt_reg;
  reg [23:0] addr_reg;
  reg [23:0] seq_addr_reg;
  reg data_ok_reg;
  reg [7:0] data_reg;
  reg wel_reg;
  reg seq_reg;
  reg epe_reg;
  reg busy_reg;
  // One timer serves both operations; they never overlap
  reg [31:0] timer_reg;
  reg [7:0] status_shift_reg;
  reg cs_low_reg;

  wire op_seq = (opcode_reg == `OP_SEQ_PROG_A) || (opcode_reg == `OP_SEQ_PROG_B); // RULE2
  wire op_erase = (opcode_reg == `OP_ERASE_4K) || (opcode_reg == `OP_ERASE_32K) ||
                  (opcode_reg == `OP_ERASE_64K);

  // ==========================================
  // Erase block mask and protection span
  // Default arm is the 64K mask; only erase opcodes reach the strobe
  reg [23:0] erase_mask;
  always @* begin
    case (opcode_reg) // RULE15
      `OP_ERASE_4K: erase_mask = `MASK_4K;
      `OP_ERASE_32K: erase_mask = `MASK_32K;
      default: erase_mask = `MASK_64K;
    endcase
  end
  wire [23:0] erase_base = addr_reg & erase_mask; // RULE18
  // Blocks never exceed one 64K sector, so one bit covers the span
  wire [3:0] erase_sector = erase_base[`SECTOR_SHIFT+3:`SECTOR_SHIFT];
  wire erase_protected = i_sector_protected[erase_sector]; // RULE20

  // Target address for this program cycle
  wire [23:0] prog_addr = seq_reg ? seq_addr_reg : addr_reg; // RULE4
  wire [3:0] prog_sector = prog_addr[`SECTOR_SHIFT+3:`SECTOR_SHIFT];
  wire prog_protected = i_sector_protected[prog_sector];
  wire [23:0] next_addr = prog_addr + 24'h000001;
  wire [3:0] next_sector = next_addr[`SECTOR_SHIFT+3:`SECTOR_SHIFT];
  wire at_end = (prog_addr == `ADDR_LAST); // RULE10
  wire next_protected = i_sector_protected[next_sector]; // RULE11

  // ==========================================
  // Command decode and execution
  always @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= S_OPCODE;
      opcode_reg <= 8'h00;
      addr_cnt_reg <= 2'h0;
      addr_reg <= 24'h000000;
      seq_addr_reg <= 24'h000000;
      data_ok_reg <= 1'b0;
      data_reg <= 8'h00;
      wel_reg <= 1'b0;
      seq_reg <= 1'b0; // RULE25
      epe_reg <= 1'b0;
      busy_reg <= 1'b0;
      timer_reg <= 32'h0;
      status_shift_reg <= 8'h00;
      cs_low_reg <= 1'b0;
      o_prog_strobe <= 1'b0;
      o_erase_strobe <= 1'b0;
      o_array_byte_address <= 24'h000000;
      o_erase_mask <= 24'h000000;
      o_prog_data <= 8'hff;
    end else begin
      o_prog_strobe <= 1'b0;
      o_erase_strobe <= 1'b0;
      // Self-timed operation
      if (busy_reg) begin
        if (timer_reg == 32'h1) begin
          busy_reg <= 1'b0;
          if (i_op_fail) begin
            epe_reg <= 1'b1; // RULE14
          end
        end
        timer_reg <= timer_reg - 32'h1;
      end
      if (frame_start) begin
        cs_low_reg <= 1'b1;
        state_reg <= S_OPCODE;
        // Stale opcode would let an empty frame commit the last command again
        opcode_reg <= 8'h00;
        addr_cnt_reg <= 2'h0;
        data_ok_reg <= 1'b0;
      end
      // Status byte advances on each falling SCK
      if (sck_fall) begin
        status_shift_reg <= {status_shift_reg[6:0], 1'b0};
      end
      if (byte_valid) begin
        case (state_reg)
          S_OPCODE: begin
            opcode_reg <= rx_byte;
            if (rx_byte == `OP_READ_STATUS) begin
              state_reg <= S_STATUS;
              status_shift_reg <= {2'b00, epe_reg, 3'b000, wel_reg, busy_reg}; // RULE12
            end else if (busy_reg) begin
              // Only status reads are served while an operation runs
              state_reg <= S_IGNORE;
            end else if ((rx_byte == `OP_SEQ_PROG_A) || (rx_byte == `OP_SEQ_PROG_B)) begin
              state_reg <= seq_reg ? S_DATA : S_ADDR; // RULE4
            end else if ((rx_byte == `OP_ERASE_4K) || (rx_byte == `OP_ERASE_32K) ||
                         (rx_byte == `OP_ERASE_64K)) begin
              state_reg <= S_ADDR; // RULE17
            end else begin
              state_reg <= S_IGNORE;
            end
          end
          S_ADDR: begin
            // Big-endian: first address byte ends up in bits 23:16
            addr_reg <= {addr_reg[15:0], rx_byte};
            addr_cnt_reg <= addr_cnt_reg + 2'h1;
            if (addr_cnt_reg == 2'h2) begin
              state_reg <= op_seq ? S_DATA : S_IGNORE; // RULE17
            end
          end
          S_DATA: begin
            data_reg <= rx_byte; // RULE7
            data_ok_reg <= 1'b1;
          end
          S_STATUS: begin
            status_shift_reg <= {2'b00, epe_reg, 3'b000, wel_reg, busy_reg}; // RULE12
          end
          default: begin
            state_reg <= S_IGNORE;
          end
        endcase
      end
      // Frame end: commit or abort
      // The aligned flag still describes this frame when frame_end arrives
      if (frame_end && cs_low_reg) begin
        cs_low_reg <= 1'b0;
        state_reg <= S_OPCODE;
        if (busy_reg || state_reg == S_STATUS) begin
          // Nothing to commit
        end else if (opcode_reg == `OP_WRITE_ENABLE && aligned) begin
          wel_reg <= 1'b1; // RULE24
        end else if (opcode_reg == `OP_WRITE_DISABLE && aligned) begin
          wel_reg <= 1'b0; // RULE23
          seq_reg <= 1'b0; // RULE6
        end else if (op_seq && state_reg != S_IGNORE) begin
          if (!wel_reg) begin
            // Entry or continuation refused without the latch
            seq_reg <= 1'b0; // RULE1
          end else if (!data_ok_reg || !aligned) begin
            wel_reg <= 1'b0; // RULE8
          end else if (prog_protected) begin
            wel_reg <= 1'b0; // RULE9
            seq_reg <= 1'b0;
          end else begin
            o_prog_strobe <= 1'b1; // RULE3
            o_array_byte_address <= prog_addr;
            o_prog_data <= data_reg;
            busy_reg <= 1'b1;
            timer_reg <= PROG_CYC;
            // No wrap and no skipping over a protected sector
            if (at_end || next_protected) begin
              seq_reg <= 1'b0; // RULE10 RULE11
              wel_reg <= 1'b0;
            end else begin
              seq_reg <= 1'b1; // RULE5
              seq_addr_reg <= next_addr;
            end
          end
        end else if (op_erase) begin
          if (!wel_reg) begin
            // Erase refused without the latch
            wel_reg <= 1'b0; // RULE16
          end else if (addr_cnt_reg != 2'h3 || !aligned) begin
            wel_reg <= 1'b0; // RULE19 RULE21
          end else if (erase_protected) begin
            wel_reg <= 1'b0; // RULE20 RULE21
          end else begin
            o_erase_strobe <= 1'b1;
            o_array_byte_address <= erase_base;
            o_erase_mask <= erase_mask;
            busy_reg <= 1'b1;
            timer_reg <= ERASE_CYC;
            wel_reg <= 1'b0; // RULE22
            seq_reg <= 1'b0;
          end
        end
      end
    end
  end

  // Bit leaves on each falling SCK, so the host samples it settled
  always @* begin
    so_bit = status_shift_reg[7];
  end

  // ==========================================
  // Outputs
  assign o_so_oe_n = ~(cs_low_reg && state_reg == S_STATUS);
  assign o_busy = busy_reg; // RULE12
  assign o_write_enable_latch = wel_reg;
  assign o_program_erase_error_flag = epe_reg;
  assign o_seq_mode = seq_reg;
endmodule // seq_prog_erase

//--- tb/spi_host_model.sv
/*
  SPI host model, mode 0 or 3 by cpol; clock stands still between frames.
  Assumes the bench calls xfer at a falling edge of the system clock.
*/
module spi_host_model (
  // SPI pins
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire i_so
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cpol;
  initial begin
    cpol = 1'b0;
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // ==========================================
  // One framed transfer, MSB first, 32 ns link clock
  task automatic xfer(input logic [47:0] d, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    // Idle level settles while CS is still high
    o_sck = cpol;
    #16 o_cs_n = 1'b0;
    #16;
    for (int i = 0; i < nb; i++) begin
      o_sck = 1'b0;
      o_si = d[47 - i];
      #16 o_sck = 1'b1;
      rx = {rx[6:0], i_so};
      #16;
    end
    o_sck = cpol;
    #16 o_cs_n = 1'b1;
    // Released line: inverse of last bit, so no stale value looks valid
    o_si = ~o_si;
    #40;
  endtask
endmodule // spi_host_model

//--- tb/seq_prog_erase_chk.sv
/*
  Checker for seq_prog_erase, bound to its ports.
  Assumes registered strobes and flags from the design.
*/
module seq_prog_erase_chk #(
  parameter int BYTE_PROGRAM_CYCLES = 20,
  parameter int BLOCK_ERASE_CYCLES = 50
) (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Watched ports
  input wire i_op_fail,
  input wire o_prog_strobe,
  input wire o_erase_strobe,
  input wire [23:0] o_array_byte_address,
  input wire [23:0] o_erase_mask,
  input wire o_busy,
  input wire o_write_enable_latch,
  input wire o_program_erase_error_flag,
  input wire o_seq_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ==========================================
  // Helpers
  logic [31:0] bcnt_reg;
  logic ker_reg, ps_reg, cont_reg;
  logic [23:0] la_reg;
  wire [31:0] lim = ker_reg ? BLOCK_ERASE_CYCLES : BYTE_PROGRAM_CYCLES;
  always @(posedge i_clk) begin
    if (i_reset) begin
      bcnt_reg <= 32'h0;
      ker_reg <= 1'b0;
      ps_reg <= 1'b0;
      cont_reg <= 1'b0;
      la_reg <= 24'h0;
    end else begin
      ps_reg <= o_prog_strobe;
      if (o_prog_strobe || o_erase_strobe) begin
        bcnt_reg <= 32'h1;
        ker_reg <= o_erase_strobe;
      end else if (o_busy) begin
        bcnt_reg <= bcnt_reg + 32'h1;
      end
      if (o_prog_strobe) begin
        la_reg <= o_array_byte_address;
      end
      // Run continues only while the mode stays up past a strobe
      if (!o_seq_mode) begin
        cont_reg <= 1'b0;
      end else if (ps_reg) begin
        cont_reg <= 1'b1;
      end
    end
  end
  // ==========================================
  // Assertions
  chk_busy_length: assert property ($fell(o_busy) |-> bcnt_reg >= lim && bcnt_reg <= lim + 2)
    else $error("busy length off");
  chk_prog_busy: assert property (o_prog_strobe |-> o_busy ##1 (!o_prog_strobe && o_busy))
    else $error("program strobe without busy");
  chk_erase_mask: assert property (o_erase_strobe |-> (o_erase_mask == 24'hfff000
    || o_erase_mask == 24'hff8000 || o_erase_mask == 24'hff0000) && (o_array_byte_address & ~o_erase_mask) == 24'h0)
    else $error("erase mask or base wrong");
  chk_erase_latch: assert property (o_erase_strobe |-> $past(o_write_enable_latch))
    else $error("erase without latch");
  chk_erase_clear: assert property ($fell(o_busy) && ker_reg |-> !o_write_enable_latch)
    else $error("latch still set after erase");
  chk_seq_next: assert property (o_prog_strobe && cont_reg |-> o_array_byte_address == la_reg + 24'h1)
    else $error("sequential address not next");
  chk_flag_sticky: assert property (!$fell(o_program_erase_error_flag))
    else $error("error flag dropped");
  chk_fail_sets: assert property ($fell(o_busy) && $past(i_op_fail) |-> ##[0:2] o_program_erase_error_flag)
    else $error("failure not flagged");
  cover property (o_prog_strobe && cont_reg);
  cover property (o_erase_strobe && o_erase_mask == 24'hff0000);
  cover property ($rose(o_program_erase_error_flag));
  cover property ($fell(o_seq_mode) && !o_write_enable_latch);
endmodule // seq_prog_erase_chk

bind seq_prog_erase seq_prog_erase_chk #(.BYTE_PROGRAM_CYCLES(BYTE_PROGRAM_CYCLES),
  .BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES)) u_chk (.i_clk(i_clk), .i_reset(i_reset),
  .i_op_fail(i_op_fail), .o_prog_strobe(o_prog_strobe), .o_erase_strobe(o_erase_strobe),
  .o_array_byte_address(o_array_byte_address), .o_erase_mask(o_erase_mask), .o_busy(o_busy),
  .o_write_enable_latch(o_write_enable_latch), .o_program_erase_error_flag(o_program_erase_error_flag),
  .o_seq_mode(o_seq_mode));

//--- tb/tb_seq_prog_erase.sv
/*
  Bench for seq_prog_erase: host model sends frames, strobes captured here.
  Assumes the defs header on the include path; short busy counts.
*/
`include "seq_prog_erase_defs.vh"
module tb_seq_prog_erase;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Signals
  localparam int P = 400;
  localparam int E = 600;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_op_fail = 1'b0;
  logic [15:0] i_sector_protected = 16'h0000;
  wire sck, cs_n, si, so, so_oe_n, prs, ers, busy, write_enable_latch, program_erase_error_flag, seqm;
  wire [23:0] addr, mask;
  wire [7:0] pdat;
  // No pull-up on SO: a released line shows the inverse of its last bit
  wire so_line = so_oe_n ? ~so : so;
  int miscompares = 0;
  int tests_run = 0;
  int np = 0;
  int ne = 0;
  logic [23:0] pa, ea, em;
  logic [7:0] pd, rx;
  seq_prog_erase #(.BYTE_PROGRAM_CYCLES(P), .BLOCK_ERASE_CYCLES(E)) u_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .o_so(so),
    .o_so_oe_n(so_oe_n), .i_sector_protected(i_sector_protected), .o_prog_strobe(prs),
    .o_erase_strobe(ers), .o_array_byte_address(addr), .o_erase_mask(mask), .o_prog_data(pdat),
    .i_op_fail(i_op_fail), .o_busy(busy), .o_write_enable_latch(write_enable_latch),
    .o_program_erase_error_flag(program_erase_error_flag), .o_seq_mode(seqm));
  spi_host_model u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so_line));
  initial forever #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (prs) begin
      np++;
      pa = addr;
      pd = pdat;
    end
    if (ers) begin
      ne++;
      ea = addr;
      em = mask;
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic idle;
    int n;
    n = 0;
    repeat (8) @(negedge i_clk);
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 3000) begin
      miscompares++;
      $display("[ERR] %0t busy stuck", $time);
      close_out;
    end
    repeat (2) @(negedge i_clk);
  endtask
  task automatic frm(input logic [47:0] d, input int nb);
    u_host.xfer(d, nb, rx);
    idle;
  endtask
  task automatic wren;
    frm({`OP_WRITE_ENABLE, 40'h0}, 8);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_seq;
    chk(seqm, 0);
    wren;
    chk(write_enable_latch, 1);
    u_host.xfer({`OP_SEQ_PROG_A, 24'h010010, 16'h5a3c}, 48, rx);
    u_host.xfer({`OP_READ_STATUS, 40'h0}, 16, rx);
    chk(rx[`STAT_BUSY_BIT], 1);
    chk(rx[`STAT_WEL_BIT], 1);
    idle;
    chk(pa, 24'h010010);
    chk(pd, 8'h3c);
    frm({`OP_SEQ_PROG_B, 8'h77, 32'h0}, 16);
    chk(np, 2);
    chk(pa, 24'h010011);
    chk(pd, 8'h77);
    frm({`OP_WRITE_DISABLE, 40'h0}, 8);
    chk({write_enable_latch, seqm}, 0);
    frm({`OP_SEQ_PROG_A, 8'h11, 32'h0}, 16);
    chk(np, 2);
    $display("t_seq done");
  endtask
  task automatic t_abort;
    wren;
    frm({`OP_SEQ_PROG_A, 24'h010020, 16'h5500}, 36);
    chk({np[7:0], write_enable_latch}, {8'h2, 1'b0});
    wren;
    frm({`OP_SEQ_PROG_A, 24'h010020, 16'h0}, 32);
    chk({np[7:0], write_enable_latch}, {8'h2, 1'b0});
    wren;
    frm({`OP_ERASE_4K, 16'h0100, 24'h0}, 24);
    chk({ne[7:0], write_enable_latch}, 0);
    frm({`OP_ERASE_4K, 24'h010000, 16'h0}, 32);
    chk(ne, 0);
    $display("t_abort done");
  endtask
  task automatic t_prot;
    i_sector_protected = 16'h0004;
    wren;
    frm({`OP_SEQ_PROG_A, 24'h020100, 16'h1200}, 40);
    chk({np[7:0], write_enable_latch, seqm}, {8'h2, 2'b00});
    wren;
    frm({`OP_ERASE_64K, 24'h028000, 16'h0}, 32);
    chk({ne[7:0], write_enable_latch}, 0);
    wren;
    frm({`OP_SEQ_PROG_A, 24'h01ffff, 16'h3400}, 40);
    chk(np, 3);
    chk(pa, 24'h01ffff);
    chk({write_enable_latch, seqm}, 0);
    i_sector_protected = 16'h0000;
    wren;
    frm({`OP_SEQ_PROG_A, `ADDR_LAST, 16'h5600}, 40);
    chk({np[7:0], write_enable_latch, seqm}, {8'h4, 2'b00});
    $display("t_prot done");
  endtask
  task automatic t_erase;
    logic [7:0] ops [3] = '{`OP_ERASE_4K, `OP_ERASE_32K, `OP_ERASE_64K};
    logic [23:0] msk [3] = '{`MASK_4K, `MASK_32K, `MASK_64K};
    chk(program_erase_error_flag, 0);
    for (int i = 0; i < 3; i++) begin
      i_op_fail = (i == 2);
      // 32K erase runs in mode 3, the others in mode 0
      u_host.cpol = (i == 1);
      wren;
      frm({ops[i], 24'h0abcde, 16'h99aa}, 48);
      chk(ne, i + 1);
      chk(ea, 24'h0abcde & msk[i]);
      chk(em, msk[i]);
      chk(write_enable_latch, 0);
    end
    u_host.cpol = 1'b0;
    chk(program_erase_error_flag, 1);
    i_op_fail = 1'b0;
    $display("t_erase done");
  endtask
  task automatic t_reset;
    wren;
    frm({`OP_SEQ_PROG_A, 24'h030000, 16'h4400}, 40);
    chk({write_enable_latch, seqm}, 2'b11);
    i_reset = 1'b1;
    repeat (4) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
    chk({write_enable_latch, seqm, program_erase_error_flag}, 0);
    frm({`OP_SEQ_PROG_A, 8'h66, 32'h0}, 16);
    chk(np, 5);
    $display("t_reset done");
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
    t_seq;
    t_abort;
    t_prot;
    t_erase;
    t_reset;
    close_out;
  end
endmodule // tb_seq_prog_erase
